/* File: inc/adcc_pkg.sv */
// package for the converter control block: register map, fields, timing
// Overview of operation
// - writing converter control register starts conversions, from the host over AXI4-Lite
// - normal mode uses 200 MHz clock, raw samples at 800 kSPS
// - raw result is 16-bit offset binary, 0x8000 means zero input
// - positive input routed from setup register bits 5 to 0
// - negative code 01000 in setup bits 12 to 8 selects bias node
// - gain stage enable front-end bit 10, gain from setup bits 18:16
// - anti-alias cutoff from power bandwidth register bits 3 to 2
// - offset and gain correction applied from the single offset and gain register pair
// - mains rejection enabled gives roughly 900 Hz result rate at 800 kSPS with third-order ratio 5
// - averaging, mean, variance, minimum and maximum of results provided
// - Fourier engine accumulates results for magnitude and phase
// - second and third order sinc filters; third-order ratio programmable, second-order fixed at 178
// - third-order sinc active when filter bit 6 zero; ratio 2, 4, 5
// - notch on when filter bit 4 clear and front-end bit 16 set
package adcc_pkg;
	localparam int unsigned ADCC_AW = 12;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_FILT = 12'h044;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_RAW = 12'h074;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_DFTR = 12'h078;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_DFTI = 12'h07c;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_SINC2 = 12'h080;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_SETUP = 12'h1a8;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_FEC = 12'h000;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_POWER_BANDWIDTH_SELECT = 12'h050;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_OFFS = 12'h200;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_GAIN = 12'h204;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_STMIN = 12'h210;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_STMAX = 12'h214;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_STMEAN = 12'h218;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_STVAR = 12'h21c;
	localparam logic [ADCC_AW-1:0] ADCC_OFS_STAT = 12'h220;
	localparam logic [31:0] ADCC_RST_FILT = 32'h0000_0301;
	localparam logic [31:0] ADCC_RST_ZERO = 32'h0000_0000;
	localparam logic [15:0] ADCC_MIDSCALE = 16'h8000;
	localparam logic [15:0] ADCC_GAIN_UNITY = 16'h4000;
	localparam int unsigned ADCC_GAIN_SHIFT = 14;
	localparam int unsigned ADCC_POS_LSB = 0;
	localparam int unsigned ADCC_POS_W = 6;
	localparam int unsigned ADCC_NEG_LSB = 8;
	localparam int unsigned ADCC_NEG_W = 5;
	localparam logic [4:0] ADCC_NEG_BIAS = 5'h08;
	localparam int unsigned ADCC_PGA_LSB = 16;
	localparam int unsigned ADCC_FEC_CONV = 8;
	localparam int unsigned ADCC_FEC_PGAEN = 10;
	localparam int unsigned ADCC_FEC_DFT = 15;
	localparam int unsigned ADCC_FEC_NOTCH = 16;
	localparam int unsigned ADCC_PM_HP = 0;
	localparam int unsigned ADCC_PM_AA_LSB = 2;
	localparam int unsigned ADCC_FT_SINC3OSR_LSB = 12;
	localparam int unsigned ADCC_FT_SINC3BYP = 6;
	localparam int unsigned ADCC_FT_NOTCHBYP = 4;
	localparam int unsigned ADCC_FT_SINC2OSR_LSB = 8;
	localparam int unsigned ADCC_FT_AVG_LSB = 14;
	localparam int unsigned ADCC_FT_AVGEN = 7;
	localparam logic [1:0] ADCC_OSR3_2 = 2'h1;
	localparam logic [1:0] ADCC_OSR3_4 = 2'h0;
	localparam real ADCC_CLK_MHZ = 200.0;
	localparam real ADCC_NORM_KSPS = 800.0;
	localparam real ADCC_HP_KSPS = 1600.0;
	localparam int unsigned ADCC_NORM_CYC = int'(ADCC_CLK_MHZ * 1000.0 / ADCC_NORM_KSPS);
	localparam int unsigned ADCC_HP_CYC = int'(ADCC_CLK_MHZ * 1000.0 / ADCC_HP_KSPS);
	localparam int unsigned ADCC_NOTCH_RATIO = 178;
	localparam int unsigned ADCC_DFT_N = 16;
	typedef enum logic [2:0] {
		ADCC_IDLE = 3'b001,
		ADCC_RUN = 3'b010,
		ADCC_OUT = 3'b100
	} adcc_state_t;
endpackage

/* File: inc/adcc_buf_if.sv */
// interface carrying result words between the control core and the output buffer
`timescale 1ns/1ps
interface adcc_buf_if;
	logic in_valid;
	logic in_ready;
	logic [15:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [15:0] out_data;
	modport buf_side (input in_valid, input in_data, output in_ready, output out_valid, output out_data,
		input out_ready);
	modport core_side (output in_valid, output in_data, input in_ready, input out_valid, input out_data,
		output out_ready);
endinterface

/* File: rtl/adcc_skid.sv */
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module adcc_skid (
	input wire logic sys_clk,
	input wire logic srst,
	adcc_buf_if.buf_side bus
);
	typedef struct packed {
		logic [1:0] cnt;
		logic [15:0] e0;
		logic [15:0] e1;
	} adcc_skid_t;
	adcc_skid_t st_ff, nxt_st;
	logic push, pop;
	assign bus.in_ready = (st_ff.cnt != 2'h2);
	assign bus.out_valid = (st_ff.cnt != 2'h0);
	assign bus.out_data = st_ff.e0;
	assign push = bus.in_valid && bus.in_ready;
	assign pop = bus.out_valid && bus.out_ready;
	always_comb begin
		nxt_st = st_ff;
		if (pop) begin
			nxt_st.e0 = st_ff.e1;
		end
		if (push) begin
			if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop)) begin
				nxt_st.e0 = bus.in_data;
			end else begin
				nxt_st.e1 = bus.in_data;
			end
		end
		nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

/* File: rtl/adcc_top.sv */
// converter control core: AXI4-Lite registers, sample timing, correction and post-processing
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module adcc_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [adcc_pkg::ADCC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [adcc_pkg::ADCC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] sar_code,
	output logic sar_sample,
	output logic [5:0] positive_input_select,
	output logic [4:0] negative_input_select,
	output logic bias_node_select,
	output logic pga_enable,
	output logic [2:0] pga_gain,
	output logic [1:0] aa_cutoff,
	output logic [15:0] result_data,
	output logic result_valid,
	input wire logic result_ready
);
	import adcc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [ADCC_AW-1:0] aw_addr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] filt;
		logic [31:0] setup;
		logic [31:0] fec;
		logic [31:0] power_bandwidth_select;
		logic [15:0] offs;
		logic [15:0] gain;
		logic [15:0] raw;
		logic [15:0] sinc2;
		logic [31:0] dft_re;
		logic [31:0] dft_im;
		logic [15:0] st_min;
		logic [15:0] st_max;
		logic [31:0] st_sum;
		logic [47:0] st_sq;
		logic [15:0] st_cnt;
		logic [15:0] mean;
		logic [31:0] var_out;
		adcc_state_t fsm;
		logic [7:0] tick;
		logic [23:0] s3_acc;
		logic [2:0] s3_cnt;
		logic [31:0] s2_acc;
		logic [7:0] s2_cnt;
		logic [19:0] av_acc;
		logic [3:0] av_cnt;
		logic [4:0] dft_cnt;
		logic [15:0] res;
		logic res_v;
		logic ovf;
	} adcc_top_t;
	adcc_top_t st_ff, nxt_st;

	adcc_buf_if obuf();
	adcc_skid u_skid (
		.sys_clk(sys_clk),
		.srst(srst),
		.bus(obuf.buf_side)
	);

	logic wr_fire, rd_fire, hp, s3_on, notch_on, avg_on;
	logic [7:0] tick_top;
	logic [2:0] s3_ratio;
	logic [16:0] off_sum;
	logic [32:0] gprod;
	logic [15:0] corr;
	logic [31:0] wmask;

	assign hp = st_ff.power_bandwidth_select[ADCC_PM_HP];
	// the output cycle belongs to the sample period, so the run count stops two short
	assign tick_top = hp ? 8'(ADCC_HP_CYC - 2) : 8'(ADCC_NORM_CYC - 2);
	assign s3_on = ~st_ff.filt[ADCC_FT_SINC3BYP];
	assign notch_on = ~st_ff.filt[ADCC_FT_NOTCHBYP] && st_ff.fec[ADCC_FEC_NOTCH];
	assign avg_on = st_ff.filt[ADCC_FT_AVGEN];
	always_comb begin
		unique case (st_ff.filt[ADCC_FT_SINC3OSR_LSB +: 2])
			ADCC_OSR3_2: s3_ratio = 3'h2;
			ADCC_OSR3_4: s3_ratio = 3'h4;
			default: s3_ratio = 3'h5;
		endcase
	end
	// offset then gain, from the single offset and gain register pair
	assign off_sum = {1'b0, sar_code} + {1'b0, st_ff.offs};
	assign gprod = {16'h0, off_sum} * {17'h0, st_ff.gain};
	assign corr = (|gprod[32:ADCC_GAIN_SHIFT+16]) ? 16'hffff : gprod[ADCC_GAIN_SHIFT +: 16];

	assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [15:0] sample;
		logic sample_v;
		logic [31:0] wd;
		sample = '0;
		sample_v = 1'b0;
		wd = '0;
		nxt_st = st_ff;
		// bus write
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata & wmask;
		end
		if (wr_fire) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = 2'b00;
			unique case (st_ff.aw_addr)
				ADCC_OFS_FILT: nxt_st.filt = st_ff.wdata;
				ADCC_OFS_SETUP: nxt_st.setup = st_ff.wdata;
				ADCC_OFS_FEC: nxt_st.fec = st_ff.wdata;
				ADCC_OFS_POWER_BANDWIDTH_SELECT: nxt_st.power_bandwidth_select = st_ff.wdata;
				ADCC_OFS_OFFS: nxt_st.offs = st_ff.wdata[15:0];
				ADCC_OFS_GAIN: nxt_st.gain = st_ff.wdata[15:0];
				ADCC_OFS_STAT: begin
					nxt_st.st_cnt = '0;
					nxt_st.st_sum = '0;
					nxt_st.st_sq = '0;
					nxt_st.st_min = 16'hffff;
					nxt_st.st_max = '0;
					nxt_st.ovf = 1'b0;
				end
				ADCC_OFS_RAW, ADCC_OFS_DFTR, ADCC_OFS_DFTI, ADCC_OFS_SINC2, ADCC_OFS_STMIN, ADCC_OFS_STMAX,
				ADCC_OFS_STMEAN, ADCC_OFS_STVAR: ;
				default: nxt_st.bresp = 2'b10;
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// bus read
		if (rd_fire) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = 2'b00;
			unique case (s_axi_araddr)
				ADCC_OFS_FILT: nxt_st.rdata = st_ff.filt;
				ADCC_OFS_SETUP: nxt_st.rdata = st_ff.setup;
				ADCC_OFS_FEC: nxt_st.rdata = st_ff.fec;
				ADCC_OFS_POWER_BANDWIDTH_SELECT: nxt_st.rdata = st_ff.power_bandwidth_select;
				ADCC_OFS_OFFS: nxt_st.rdata = {16'h0, st_ff.offs};
				ADCC_OFS_GAIN: nxt_st.rdata = {16'h0, st_ff.gain};
				ADCC_OFS_RAW: nxt_st.rdata = {16'h0, st_ff.raw};
				ADCC_OFS_SINC2: nxt_st.rdata = {16'h0, st_ff.sinc2};
				ADCC_OFS_DFTR: nxt_st.rdata = st_ff.dft_re;
				ADCC_OFS_DFTI: nxt_st.rdata = st_ff.dft_im;
				ADCC_OFS_STMIN: nxt_st.rdata = {16'h0, st_ff.st_min};
				ADCC_OFS_STMAX: nxt_st.rdata = {16'h0, st_ff.st_max};
				ADCC_OFS_STMEAN: nxt_st.rdata = {16'h0, st_ff.mean};
				ADCC_OFS_STVAR: nxt_st.rdata = st_ff.var_out;
				ADCC_OFS_STAT: nxt_st.rdata = {14'h0, st_ff.ovf, st_ff.fsm != ADCC_IDLE, st_ff.st_cnt};
				default: begin
					nxt_st.rdata = '0;
					nxt_st.rresp = 2'b10;
				end
			endcase
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		// conversion sequencing
		unique case (st_ff.fsm)
			ADCC_IDLE: begin
				nxt_st.tick = '0;
				if (st_ff.fec[ADCC_FEC_CONV]) begin
					nxt_st.fsm = ADCC_RUN;
				end
			end
			ADCC_RUN: begin
				if (!st_ff.fec[ADCC_FEC_CONV]) begin
					nxt_st.fsm = ADCC_IDLE;
				end else if (st_ff.tick >= tick_top) begin
					nxt_st.tick = '0;
					nxt_st.fsm = ADCC_OUT;
				end else begin
					nxt_st.tick = st_ff.tick + 8'h1;
				end
			end
			ADCC_OUT: begin
				nxt_st.fsm = ADCC_RUN;
				nxt_st.raw = corr;
				sample = corr;
				sample_v = 1'b1;
				// third-order sinc approximated as a boxcar of the chosen ratio
				if (s3_on) begin
					sample_v = 1'b0;
					nxt_st.s3_acc = st_ff.s3_acc + {8'h0, corr};
					nxt_st.s3_cnt = st_ff.s3_cnt + 3'h1;
					if (st_ff.s3_cnt + 3'h1 >= s3_ratio) begin
						sample = 16'((st_ff.s3_acc + {8'h0, corr}) / {21'h0, s3_ratio});
						sample_v = 1'b1;
						nxt_st.s3_acc = '0;
						nxt_st.s3_cnt = '0;
					end
				end
				// mains notch: decimate by the notch ratio
				if (sample_v && notch_on) begin
					nxt_st.s2_acc = st_ff.s2_acc + {16'h0, sample};
					nxt_st.s2_cnt = st_ff.s2_cnt + 8'h1;
					sample_v = 1'b0;
					if (st_ff.s2_cnt + 8'h1 >= 8'(ADCC_NOTCH_RATIO)) begin
						sample = 16'((st_ff.s2_acc + {16'h0, sample}) / 32'(ADCC_NOTCH_RATIO));
						sample_v = 1'b1;
						nxt_st.sinc2 = sample;
						nxt_st.s2_acc = '0;
						nxt_st.s2_cnt = '0;
					end
				end
				// averaging over 2^n results
				if (sample_v && avg_on) begin
					nxt_st.av_acc = st_ff.av_acc + {4'h0, sample};
					nxt_st.av_cnt = st_ff.av_cnt + 4'h1;
					sample_v = 1'b0;
					if (st_ff.av_cnt + 4'h1 == (4'h1 << st_ff.filt[ADCC_FT_AVG_LSB +: 2])) begin
						sample = 16'((st_ff.av_acc + {4'h0, sample}) >> st_ff.filt[ADCC_FT_AVG_LSB +: 2]);
						sample_v = 1'b1;
						nxt_st.av_acc = '0;
						nxt_st.av_cnt = '0;
					end
				end
				if (sample_v) begin
					nxt_st.res = sample;
					nxt_st.res_v = 1'b1;
					// pending word lost only when the buffer cannot take it this cycle
					if (st_ff.res_v && !obuf.in_ready) begin
						nxt_st.ovf = 1'b1;
					end
					// statistics; built on nxt_st so a clear in the same cycle keeps this sample
					nxt_st.st_cnt = nxt_st.st_cnt + 16'h1;
					nxt_st.st_sum = nxt_st.st_sum + {16'h0, sample};
					nxt_st.st_sq = nxt_st.st_sq + {16'h0, 32'(sample) * 32'(sample)};
					if (sample < nxt_st.st_min) begin
						nxt_st.st_min = sample;
					end
					if (sample > nxt_st.st_max) begin
						nxt_st.st_max = sample;
					end
					nxt_st.mean = 16'(nxt_st.st_sum / {16'h0, nxt_st.st_cnt});
					nxt_st.var_out = 32'(nxt_st.st_sq / {32'h0, nxt_st.st_cnt}) - 32'(nxt_st.mean) * 32'(nxt_st.mean);
					// Fourier engine: signed sample against quarter-rate reference
					if (st_ff.fec[ADCC_FEC_DFT]) begin
						wd = {{16{~sample[15]}}, ~sample[15], sample[14:0]};
						unique case (st_ff.dft_cnt[1:0])
							2'h0: nxt_st.dft_re = st_ff.dft_re + wd;
							2'h1: nxt_st.dft_im = st_ff.dft_im - wd;
							2'h2: nxt_st.dft_re = st_ff.dft_re - wd;
							default: nxt_st.dft_im = st_ff.dft_im + wd;
						endcase
						nxt_st.dft_cnt = (st_ff.dft_cnt == 5'(ADCC_DFT_N - 1)) ? 5'h0 : st_ff.dft_cnt + 5'h1;
					end
				end
			end
			default: nxt_st.fsm = ADCC_IDLE;
		endcase
		if (st_ff.res_v && obuf.in_ready) begin
			nxt_st.res_v = (st_ff.fsm == ADCC_OUT) && sample_v;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.filt <= ADCC_RST_FILT;
			st_ff.gain <= ADCC_GAIN_UNITY;
			st_ff.offs <= ADCC_RST_ZERO[15:0];
			st_ff.raw <= ADCC_MIDSCALE;
			st_ff.st_min <= 16'hffff;
			st_ff.fsm <= ADCC_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign obuf.in_valid = st_ff.res_v;
	assign obuf.in_data = st_ff.res;
	assign obuf.out_ready = result_ready;
	assign result_valid = obuf.out_valid;
	assign result_data = obuf.out_data;
	assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
	assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign sar_sample = (st_ff.fsm == ADCC_OUT);
	assign positive_input_select = st_ff.setup[ADCC_POS_LSB +: ADCC_POS_W];
	assign negative_input_select = st_ff.setup[ADCC_NEG_LSB +: ADCC_NEG_W];
	assign bias_node_select = (st_ff.setup[ADCC_NEG_LSB +: ADCC_NEG_W] == ADCC_NEG_BIAS);
	assign pga_enable = st_ff.fec[ADCC_FEC_PGAEN];
	assign pga_gain = st_ff.setup[ADCC_PGA_LSB +: 3];
	assign aa_cutoff = st_ff.power_bandwidth_select[ADCC_PM_AA_LSB +: 2];
endmodule

/* File: dv/adcc_assertions.sv */
// checker: decode and timing relations on the converter control top ports
`timescale 1ns/1ps
module adcc_assertions (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [adcc_pkg::ADCC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sar_sample,
	input wire logic [4:0] negative_input_select,
	input wire logic bias_node_select,
	input wire logic [15:0] result_data,
	input wire logic result_valid,
	input wire logic result_ready
);
	import adcc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// sample spacing helper
	// ----------------------------------------
	// gaps of 300 or more are restarts after a stop, not cadence
	logic [8:0] gap_ff;
	logic seen_ff;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gap_ff <= 9'h000;
			seen_ff <= 1'b0;
		end else if (sar_sample) begin
			gap_ff <= 9'h001;
			seen_ff <= 1'b1;
		end else if (gap_ff != 9'h1ff) begin
			gap_ff <= gap_ff + 9'h001;
		end
	end
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_bias_decode: assert property (bias_node_select == (negative_input_select == 5'h08))
		else $error("bias select disagrees with negative input code");
	a_sample_pulse: assert property (sar_sample |=> !sar_sample)
		else $error("sample strobe longer than one cycle");
	a_sample_gap: assert property (sar_sample && seen_ff && gap_ff < 9'h12c |->
		gap_ff == 9'h0fa || gap_ff == 9'h07d) else $error("sample spacing wrong");
	a_write_resp: assert property (s_wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_resp: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_unmapped_rd: assert property (s_rd_take and s_axi_araddr == 12'hffc |=>
		s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	a_result_hold: assert property (result_valid && !result_ready |=>
		result_valid && $stable(result_data)) else $error("stalled result changed");
endmodule
bind adcc_top adcc_assertions chk_u (.sys_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sar_sample,
	.negative_input_select, .bias_node_select, .result_data, .result_valid, .result_ready);

/* File: dv/adcc_sar_model.sv */
// behavioural converter core: offers a raw code at each sample strobe
`timescale 1ns/1ps
module adcc_sar_model (
	input wire logic sar_sample,
	input wire logic [15:0] level,
	output logic [15:0] sar_code
);
	// code is not held outside the strobe, so show its inverse there
	assign sar_code = sar_sample ? level : ~level;
endmodule

/* File: dv/tb_top.sv */
// testbench: register access, mux fields, sample cadence, filters and result stall
`timescale 1ns/1ps
module tb_top;
	import adcc_pkg::*;
	logic sys_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, result_ready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sar_sample;
	logic bias_node_select, pga_enable, result_valid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, aa_cutoff;
	logic [15:0] sar_code, result_data, level;
	logic [5:0] positive_input_select;
	logic [4:0] negative_input_select;
	logic [2:0] pga_gain;
	int mismatches, n_checks, cyc;
	adcc_top dut_u (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sar_code, .sar_sample, .positive_input_select, .negative_input_select,
		.bias_node_select, .pga_enable, .pga_gain, .aa_cutoff, .result_data, .result_valid, .result_ready);
	adcc_sar_model sar_u (.sar_sample, .level, .sar_code);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("counts checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wo(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(32'(r), 32'h0);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(32'(r), 32'h0);
		chk(d, e);
	endtask
	// skips two results so filter history has settled, then times one interval
	task automatic gap(output int g, output logic [15:0] q);
		repeat (2) do @(posedge sys_clk); while (!(result_valid === 1'b1 && result_ready));
		g = 0;
		do begin
			@(posedge sys_clk);
			g++;
		end while (!(result_valid === 1'b1 && result_ready));
		q = result_data;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			close_out();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int g;
		logic [15:0] q;
		logic [31:0] d;
		logic [1:0] r;
		logic [1:0] oc [3];
		int osr [3];
		oc = '{2'h1, 2'h0, 2'h2};
		osr = '{2, 4, 5};
		{srst, result_ready, s_axi_wstrb, level} <= {1'b1, 1'b1, 4'hf, 16'h9000};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rc(ADCC_OFS_FILT, ADCC_RST_FILT);
		rc(ADCC_OFS_RAW, 32'h0000_8000);
		rc(ADCC_OFS_GAIN, 32'h0000_4000);
		rc(ADCC_OFS_SETUP, 32'h0);
		rd(12'hffc, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'h2);
		// late rready: the read answer must stand until taken
		s_axi_araddr <= ADCC_OFS_GAIN;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(32'(s_axi_rvalid), 32'h1);
		chk(s_axi_rdata, 32'h4000);
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		wr(12'hffc, 32'h1, r);
		chk(32'(r), 32'h2);
		$display("test register_map done");
		wo(ADCC_OFS_SETUP, 32'h0002_082b);
		wo(ADCC_OFS_FEC, 32'h400);
		wo(ADCC_OFS_POWER_BANDWIDTH_SELECT, 32'h8);
		repeat (2) @(posedge sys_clk);
		chk(32'({positive_input_select, negative_input_select, bias_node_select}), 32'had1);
		chk(32'({pga_enable, pga_gain, aa_cutoff}), 32'h2a);
		wo(ADCC_OFS_SETUP, 32'h0002_0b2b);
		repeat (2) @(posedge sys_clk);
		chk(32'(bias_node_select), 32'h0);
		$display("test input_select done");
		wo(ADCC_OFS_OFFS, 32'h100);
		wo(ADCC_OFS_FILT, 32'h50);
		wo(ADCC_OFS_FEC, 32'h500);
		gap(g, q);
		chk(g, 250);
		chk(32'(q), 32'h9100);
		rc(ADCC_OFS_RAW, 32'h9100);
		wo(ADCC_OFS_GAIN, 32'h2000);
		gap(g, q);
		chk(32'(q), 32'h4880);
		wo(ADCC_OFS_GAIN, 32'h4000);
		for (int i = 0; i < 3; i++) begin
			wo(ADCC_OFS_FILT, {18'h0, oc[i], 12'h010});
			gap(g, q);
			chk(g, osr[i] * 250);
			chk(32'(q), 32'h9100);
		end
		$display("test conversion done");
		// stop first so the cadence change never lands mid-interval
		wo(ADCC_OFS_FEC, 32'h400);
		repeat (300) @(posedge sys_clk);
		wo(ADCC_OFS_POWER_BANDWIDTH_SELECT, 32'h9);
		wo(ADCC_OFS_FILT, 32'h50);
		wo(ADCC_OFS_FEC, 32'h500);
		gap(g, q);
		chk(g, 125);
		result_ready <= 1'b0;
		repeat (1000) @(posedge sys_clk);
		chk(32'(result_valid), 32'h1);
		rd(ADCC_OFS_STAT, d, r);
		chk(32'(d[17]), 32'h1);
		result_ready <= 1'b1;
		gap(g, q);
		chk(32'(q), 32'h9100);
		$display("test high_power_stall done");
		// average of two, sinc3 and notch bypassed, statistics cleared first
		wo(ADCC_OFS_FILT, 32'h40d0);
		wo(ADCC_OFS_STAT, 32'h0);
		gap(g, q);
		chk(g, 250);
		chk(32'(q), 32'h9100);
		rc(ADCC_OFS_STMIN, 32'h9100);
		rc(ADCC_OFS_STMAX, 32'h9100);
		rc(ADCC_OFS_STMEAN, 32'h9100);
		rc(ADCC_OFS_STVAR, 32'h0);
		$display("test averaging_statistics done");
		// notch on: 178 samples at the high power cadence before one notch word
		wo(ADCC_OFS_FILT, 32'h40);
		wo(ADCC_OFS_FEC, 32'h1_0500);
		repeat (22500) @(posedge sys_clk);
		rc(ADCC_OFS_SINC2, 32'h9100);
		$display("test mains_notch done");
		close_out();
	end
endmodule
